/* rtl/adc_audio_output_port.sv */
// audio output port: pcm master/slave framing, stream output, wishbone registers
`timescale 1ns/10ps

module adc_audio_output_port
  import adc_port_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // wishbone classic slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // pins
  input wire logic i_power_down_n,
  input wire logic i_clock_role_select,
  input wire logic i_serial_bit_clock,
  output logic o_serial_bit_clock,
  output logic o_serial_bit_clock_oe,
  input wire logic i_frame_clock,
  output logic o_frame_clock,
  output logic o_frame_clock_oe,
  output logic [1:0] o_pcm_data_out,
  output logic o_stream_bit_clock,
  output logic [1:0] o_stream_left_out,
  output logic [1:0] o_stream_right_out
);

  // ==========================================================
  // declarations
  logic [31:0] ctrl; // control register
  logic [31:0] pcm_word [2]; // per-line sample word
  logic [31:0] stream_word; // stream bit patterns, one byte per output
  logic [31:0] status; // assembled status word
  logic wb_req; // request pending this cycle
  logic pd_low; // filtered power-down level
  logic chan_reset; // all channels held in reset
  mode_e mode; // operating mode, changes only through reset
  logic role_s1; // role pin first stage
  logic role_s2; // role pin synchronised
  logic [1:0] role_ok; // both role stages hold real pin samples once bit 1 is set
  logic bclk_s1; // slave bit clock first stage
  logic bclk_s2; // slave bit clock synchronised
  logic bclk_s3; // delayed copy for edges
  logic frame_clock_s1; // slave frame clock first stage
  logic frame_clock_s2; // slave frame clock synchronised
  logic lr_prev; // frame clock at previous bit rise
  logic frame_pending; // slave frame start seen at a bit rise
  logic s_rise; // slave bit clock rising
  logic s_fall; // slave bit clock falling
  logic m_clk; // master bit clock
  logic m_rise; // master bit clock rising pulse
  logic m_fall; // master bit clock falling pulse
  logic bit_fall; // launch edge of the pcm bit clock
  logic [9:0] frame_bits; // bits in one frame
  logic [9:0] last_bit; // index of final bit in a frame
  logic [9:0] bit_cnt; // bit position in the frame
  logic [9:0] next_bit_cnt; // position after the next launch edge
  logic frame_out; // master frame clock level
  logic frame_rise_evt; // a new frame begins
  logic [9:0] valid_cnt; // frames counted since reset release
  logic pcm_valid; // pcm data may be shown
  logic [7:0] stream_bit_clock_half; // stream clock half period
  logic d_clk; // stream bit clock
  logic d_rise; // stream clock rising pulse
  logic d_fall; // stream clock falling pulse
  logic d_launch; // stream launch edge
  logic [2:0] stream_idx; // stream bit index within a byte
  logic [3:0] stream_bits; // stream outputs before mapping

  // ==========================================================
  // byte-lane merge for wishbone writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ==========================================================
  // wishbone slave
  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;

  // ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_wb_ack <= 1'b0;
    end
    else
    begin
      o_wb_ack <= wb_req;
    end
  end

  // register writes, applied with the ack
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      ctrl <= CTRL_RESET;
      pcm_word[0] <= 32'h0000_0000;
      pcm_word[1] <= 32'h0000_0000;
      stream_word <= 32'h0000_0000;
    end
    else if (wb_req && i_wb_we)
    begin
      case (i_wb_adr)
        REG_CTRL: ctrl <= merge_bytes(ctrl, i_wb_dat, i_wb_sel);
        REG_PCM_DATA0: pcm_word[0] <= merge_bytes(pcm_word[0], i_wb_dat, i_wb_sel);
        REG_PCM_DATA1: pcm_word[1] <= merge_bytes(pcm_word[1], i_wb_dat, i_wb_sel);
        REG_STREAM_DATA: stream_word <= merge_bytes(stream_word, i_wb_dat, i_wb_sel);
        // unmapped and status: write ignored
        default: ctrl <= ctrl;
      endcase
    end
  end

  // status word shows the block's own state
  always_comb
  begin
    status = 32'h0000_0000;
    status[STAT_VALID_BIT] = pcm_valid;
    status[STAT_RESET_BIT] = chan_reset;
    status[STAT_MASTER_BIT] = (mode == MODE_PCM_MASTER);
    status[STAT_STREAM_BIT] = (mode == MODE_STREAM);
    status[STAT_SLAVE_BIT] = (mode == MODE_PCM_SLAVE);
    status[STAT_COUNT_LSB +: 10] = valid_cnt;
  end

  // read data registered with the ack; unmapped reads zero
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_wb_dat <= 32'h0000_0000;
    end
    else if (wb_req && !i_wb_we)
    begin
      case (i_wb_adr)
        REG_CTRL: o_wb_dat <= ctrl;
        REG_PCM_DATA0: o_wb_dat <= pcm_word[0];
        REG_PCM_DATA1: o_wb_dat <= pcm_word[1];
        REG_STREAM_DATA: o_wb_dat <= stream_word;
        REG_STATUS: o_wb_dat <= status;
        default: o_wb_dat <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // power-down and channel reset
  pd_filter u_pd_filter (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_power_down_n(i_power_down_n),
    .o_held_low(pd_low)
  );

  // any reset source holds every channel
  assign chan_reset = pd_low | ~ctrl[CTRL_SRST_BIT] | (ctrl[CTRL_PWR_LSB +: 4] == 4'h0);

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      role_s1 <= 1'b0;
      role_s2 <= 1'b0;
      role_ok <= 2'h0;
      bclk_s1 <= 1'b0;
      bclk_s2 <= 1'b0;
      bclk_s3 <= 1'b0;
      frame_clock_s1 <= 1'b0;
      frame_clock_s2 <= 1'b0;
    end
    else
    begin
      role_s1 <= i_clock_role_select;
      role_s2 <= role_s1;
      role_ok <= {role_ok[0], 1'b1};
      bclk_s1 <= i_serial_bit_clock;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
      frame_clock_s1 <= i_frame_clock;
      frame_clock_s2 <= frame_clock_s1;
    end
  end

  assign s_rise = bclk_s2 & ~bclk_s3;
  assign s_fall = ~bclk_s2 & bclk_s3;

  // ==========================================================
  // mode selection, latched once channel reset releases, held in reset while it is set
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      mode <= MODE_RESET;
    end
    // wait for the role synchroniser to fill, else the reset value picks the role
    else if (chan_reset || !role_ok[1])
    begin
      mode <= MODE_RESET;
    end
    else
    begin
      case (mode)
        MODE_RESET:
        begin
          // format bit picks pcm or stream
          if (ctrl[CTRL_FORMAT_BIT] == FMT_STREAM)
          begin
            mode <= MODE_STREAM;
          end
          else if (role_s2)
          begin
            mode <= MODE_PCM_MASTER;
          end
          else
          begin
            mode <= MODE_PCM_SLAVE;
          end
        end
        MODE_PCM_MASTER: mode <= MODE_PCM_MASTER;
        MODE_PCM_SLAVE: mode <= MODE_PCM_SLAVE;
        MODE_STREAM: mode <= MODE_STREAM;
        default: mode <= MODE_RESET;
      endcase
    end
  end

  // ==========================================================
  // pcm framing
  // master bit clock from the reference
  clk_divider u_bclk_div (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_run(mode == MODE_PCM_MASTER),
    .i_half(BCLK_HALF_CYC),
    .o_clk(m_clk),
    .o_rise(m_rise),
    .o_fall(m_fall)
  );

  // frame length from the frame format field
  always_comb
  begin
    case (ctrl[CTRL_TDM_LSB +: 2])
      TDM_128: frame_bits = FRAME_BITS_128;
      TDM_256: frame_bits = FRAME_BITS_256;
      TDM_512: frame_bits = FRAME_BITS_512;
      default: frame_bits = FRAME_BITS_NORMAL;
    endcase
    last_bit = frame_bits - 10'h001;
  end

  assign bit_fall = (mode == MODE_PCM_MASTER) ? m_fall : ((mode == MODE_PCM_SLAVE) & s_fall);

  // slave frame starts at a frame clock rise
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      lr_prev <= 1'b0;
      frame_pending <= 1'b0;
    end
    else if (mode != MODE_PCM_SLAVE)
    begin
      lr_prev <= 1'b0;
      frame_pending <= 1'b0;
    end
    else if (s_rise)
    begin
      lr_prev <= frame_clock_s2;
      frame_pending <= frame_clock_s2 & ~lr_prev;
    end
  end

  // next bit position: master wraps on frame length, slave on frame clock
  always_comb
  begin
    if (mode == MODE_PCM_SLAVE)
    begin
      next_bit_cnt = frame_pending ? 10'h000 : bit_cnt + 10'h001;
    end
    else
    begin
      next_bit_cnt = (bit_cnt >= last_bit) ? 10'h000 : bit_cnt + 10'h001;
    end
  end

  assign frame_rise_evt = bit_fall & (next_bit_cnt == 10'h000);

  // bit counter and master frame clock, one period per sample
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      bit_cnt <= 10'h3ff;
      frame_out <= 1'b0;
    end
    else if (mode == MODE_RESET || mode == MODE_STREAM)
    begin
      // restart so the first frame is whole
      bit_cnt <= last_bit;
      frame_out <= 1'b0;
    end
    else if (bit_fall)
    begin
      bit_cnt <= next_bit_cnt;
      frame_out <= (next_bit_cnt < FRAME_HIGH_BITS);
    end
  end

  // count frames after release before data is valid
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      valid_cnt <= 10'h000;
    end
    else if (chan_reset)
    begin
      valid_cnt <= 10'h000;
    end
    else if (frame_rise_evt && valid_cnt < VALID_FRAMES)
    begin
      valid_cnt <= valid_cnt + 10'h001;
    end
  end

  assign pcm_valid = (valid_cnt == VALID_FRAMES);

  // shift each line msb first on the falling bit clock
  genvar gl;
  generate
    for (gl = 0; gl < 2; gl++)
    begin : g_pcm_line
      always_ff @(posedge i_mclk or posedge i_sys_rst)
      begin
        if (i_sys_rst)
        begin
          o_pcm_data_out[gl] <= 1'b0;
        end
        // static low while held or not yet valid
        else if (mode == MODE_RESET || mode == MODE_STREAM || !pcm_valid)
        begin
          o_pcm_data_out[gl] <= 1'b0;
        end
        else if (bit_fall)
        begin
          o_pcm_data_out[gl] <= pcm_word[gl][~next_bit_cnt[4:0]];
        end
      end
    end
  endgenerate

  // drive link clocks only as master
  assign o_serial_bit_clock = m_clk;
  assign o_serial_bit_clock_oe = (mode == MODE_PCM_MASTER);
  assign o_frame_clock = frame_out;
  assign o_frame_clock_oe = (mode == MODE_PCM_MASTER);

  // ==========================================================
  // stream output
  always_comb
  begin
    case (ctrl[CTRL_RATE_LSB +: 2])
      RATE_256: stream_bit_clock_half = STREAM_BIT_CLOCK_HALF_256;
      RATE_128: stream_bit_clock_half = STREAM_BIT_CLOCK_HALF_128;
      default: stream_bit_clock_half = STREAM_BIT_CLOCK_HALF_64;
    endcase
  end

  clk_divider u_stream_bit_clock_div (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_run(mode == MODE_STREAM),
    .i_half(stream_bit_clock_half),
    .o_clk(d_clk),
    .o_rise(d_rise),
    .o_fall(d_fall)
  );

  assign d_launch = ctrl[CTRL_EDGE_BIT] ? d_rise : d_fall;
  assign o_stream_bit_clock = d_clk;

  // stream bit index walks each byte msb first
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      stream_idx <= 3'h7;
    end
    else if (mode != MODE_STREAM)
    begin
      stream_idx <= 3'h7;
    end
    else if (d_launch)
    begin
      stream_idx <= stream_idx - 3'h1;
    end
  end

  // four stream outputs from the pattern bytes
  genvar gs;
  generate
    for (gs = 0; gs < 4; gs++)
    begin : g_stream_line
      always_ff @(posedge i_mclk or posedge i_sys_rst)
      begin
        if (i_sys_rst)
        begin
          stream_bits[gs] <= 1'b0;
        end
        else if (mode != MODE_STREAM)
        begin
          stream_bits[gs] <= 1'b0;
        end
        else if (d_launch)
        begin
          stream_bits[gs] <= stream_word[8*gs + 32'(stream_idx)];
        end
      end
    end
  endgenerate

  // byte 0 left 1, byte 1 right 1, byte 2 left 2, byte 3 right 2
  assign o_stream_left_out = {stream_bits[2], stream_bits[0]};
  assign o_stream_right_out = {stream_bits[3], stream_bits[1]};

endmodule

/* rtl/adc_port_pkg.sv */
// shared constants, register map and mode states of the audio output port
package adc_port_pkg;

  // ==========================================================
  // register map (byte addresses on the wishbone bus)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PCM_DATA0 = 8'h04;
  localparam logic [7:0] REG_PCM_DATA1 = 8'h08;
  localparam logic [7:0] REG_STREAM_DATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // ==========================================================
  // control register fields
  localparam int CTRL_FORMAT_BIT = 0;
  localparam int CTRL_EDGE_BIT = 1;
  localparam int CTRL_RATE_LSB = 2;
  localparam int CTRL_TDM_LSB = 4;
  localparam int CTRL_SRST_BIT = 6;
  localparam int CTRL_PWR_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0f40;

  // ==========================================================
  // status register fields
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_RESET_BIT = 1;
  localparam int STAT_MASTER_BIT = 2;
  localparam int STAT_STREAM_BIT = 3;
  localparam int STAT_SLAVE_BIT = 4;
  localparam int STAT_COUNT_LSB = 16;

  // ==========================================================
  // field encodings
  localparam logic FMT_PCM = 1'b0;
  localparam logic FMT_STREAM = 1'b1;
  localparam logic [1:0] RATE_64 = 2'h0;
  localparam logic [1:0] RATE_128 = 2'h1;
  localparam logic [1:0] RATE_256 = 2'h2;
  localparam logic [1:0] TDM_NORMAL = 2'h0;
  localparam logic [1:0] TDM_128 = 2'h1;
  localparam logic [1:0] TDM_256 = 2'h2;
  localparam logic [1:0] TDM_512 = 2'h3;

  // ==========================================================
  // frame shapes in bit clocks
  localparam logic [9:0] FRAME_BITS_NORMAL = 10'h040;
  localparam logic [9:0] FRAME_BITS_128 = 10'h080;
  localparam logic [9:0] FRAME_BITS_256 = 10'h100;
  localparam logic [9:0] FRAME_BITS_512 = 10'h200;
  localparam logic [9:0] FRAME_HIGH_BITS = 10'h020;

  // ==========================================================
  // timing
  localparam int MCLK_PERIOD_NS = 10;
  localparam int PD_REJECT_NS = 30;
  localparam int PD_MIN_NS = 150;
  localparam int PD_REJECT_CYC_INT = (PD_REJECT_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam logic [3:0] PD_REJECT_CYC = 4'(PD_REJECT_CYC_INT);
  localparam logic [9:0] VALID_FRAMES = 10'h247;
  localparam logic [7:0] BCLK_HALF_CYC = 8'h08;
  localparam logic [7:0] STREAM_BIT_CLOCK_HALF_64 = 8'h08;
  localparam logic [7:0] STREAM_BIT_CLOCK_HALF_128 = 8'h04;
  localparam logic [7:0] STREAM_BIT_CLOCK_HALF_256 = 8'h02;

  // ==========================================================
  // operating modes
  typedef enum logic [1:0] {
    MODE_RESET,
    MODE_PCM_MASTER,
    MODE_PCM_SLAVE,
    MODE_STREAM
  } mode_e;

endpackage

/* rtl/clk_divider.sv */
// divider making a square bit clock with one-cycle edge pulses
`timescale 1ns/10ps
module clk_divider
  import adc_port_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_run,
  input wire logic [7:0] i_half,
  output logic o_clk,
  output logic o_rise,
  output logic o_fall
);

  logic [7:0] cnt; // cycles into the current half period
  logic at_end; // last cycle of a half period

  assign at_end = (cnt == i_half - 8'h01);

  // half-period counter and clock toggle; stopped clock sits low
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cnt <= 8'h00;
      o_clk <= 1'b0;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end
    else if (!i_run)
    begin
      cnt <= 8'h00;
      o_clk <= 1'b0;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end
    else if (at_end)
    begin
      cnt <= 8'h00;
      o_clk <= ~o_clk;
      o_rise <= ~o_clk;
      o_fall <= o_clk;
    end
    else
    begin
      cnt <= cnt + 8'h01;
      o_rise <= 1'b0;
      o_fall <= 1'b0;
    end
  end

endmodule

/* rtl/pd_filter.sv */
// power-down pin synchroniser with short-pulse rejection
`timescale 1ns/10ps
module pd_filter
  import adc_port_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_power_down_n,
  output logic o_held_low
);

  logic pd_s1; // first sync stage, read only by pd_s2
  logic pd_s2; // synchronised pin level
  logic [3:0] low_cnt; // consecutive low cycles seen

  // two-stage synchroniser, idle high
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pd_s1 <= 1'b1;
      pd_s2 <= 1'b1;
    end
    else
    begin
      pd_s1 <= i_power_down_n;
      pd_s2 <= pd_s1;
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      low_cnt <= 4'h0;
      o_held_low <= 1'b0;
    end
    else if (pd_s2)
    begin
      low_cnt <= 4'h0;
      o_held_low <= 1'b0;
    end
    else if (low_cnt < PD_REJECT_CYC)
    begin
      low_cnt <= low_cnt + 4'h1;
    end
    else
    begin
      o_held_low <= 1'b1;
    end
  end

endmodule

/* bench/adc_port_monitor.sv */
// checker of bus handshake and link clock timing of the audio output port
`timescale 1ns/10ps
module adc_port_monitor
(
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic o_serial_bit_clock,
  input wire logic o_serial_bit_clock_oe,
  input wire logic o_frame_clock,
  input wire logic o_frame_clock_oe,
  input wire logic [1:0] o_pcm_data_out,
  input wire logic o_stream_bit_clock
);
  // ==========================================================
  // every check runs on the reference clock
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  // ==========================================================
  // bus answers: one pulse, one cycle after the request, never unasked
  a_ack_single_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  a_ack_prompt: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not answered in one cycle");
  a_ack_idle: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
    else $error("ack without a request");

  // ==========================================================
  // link clocks: both driven together, bit clock half period of 8
  a_oe_pair: assert property (o_serial_bit_clock_oe == o_frame_clock_oe)
    else $error("bit and frame clock enables differ");
  a_bit_half_period: assert property ($rose(o_serial_bit_clock) && o_serial_bit_clock_oe
    |=> (o_serial_bit_clock || !o_serial_bit_clock_oe)[*7]
    ##1 (!o_serial_bit_clock || !o_serial_bit_clock_oe))
    else $error("bit clock high time wrong");
  a_frame_on_fall: assert property (o_frame_clock_oe && $past(o_frame_clock_oe)
    && $changed(o_frame_clock) |-> $past(o_serial_bit_clock, 2) && !$past(o_serial_bit_clock))
    else $error("frame clock moved off the bit clock fall");
  a_data_on_fall: assert property (o_frame_clock_oe && $past(o_frame_clock_oe)
    && $changed(o_pcm_data_out) |-> $past(o_serial_bit_clock, 2) && !$past(o_serial_bit_clock))
    else $error("pcm data moved off the bit clock fall");
  // stream mode never drives pcm clocks or data
  a_stream_master: assert property (o_stream_bit_clock
    |-> !o_serial_bit_clock_oe && o_pcm_data_out == 2'h0)
    else $error("pcm link active in stream mode");
endmodule
bind adc_audio_output_port adc_port_monitor u_adc_port_monitor (.i_mclk, .i_sys_rst,
  .i_wb_cyc, .i_wb_stb, .o_wb_ack, .o_serial_bit_clock, .o_serial_bit_clock_oe,
  .o_frame_clock, .o_frame_clock_oe, .o_pcm_data_out, .o_stream_bit_clock);

/* bench/audio_host_model.sv */
// host model driving bit and frame clocks into a slave port
`timescale 1ns/10ps
module audio_host_model
(
  input wire logic i_run,
  output logic o_bit_clock,
  output logic o_frame_clock
);
  int bit_num; // bit index within the frame

  // ==========================================================
  // clocks from one source
  initial
  begin
    o_bit_clock = 1'b0;
    o_frame_clock = 1'b0;
    bit_num = 0;
    #3;
    forever
    begin
      if (!i_run)
      begin
        // clock stands low outside frames
        o_bit_clock = 1'b0;
        bit_num = 0;
        #80;
      end
      else
      begin
        #80 o_bit_clock = 1'b1;
        #80 o_bit_clock = 1'b0;
        o_frame_clock = (bit_num < 32);
        bit_num = (bit_num + 1) % 64;
      end
    end
  end
endmodule

/* bench/adc_audio_output_port_test.sv */
// self-checking bench of the audio output port
`timescale 1ns/10ps
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module adc_audio_output_port_test;
  import adc_port_pkg::*;
  logic i_mclk, i_sys_rst, i_wb_cyc, i_wb_stb, i_wb_we, i_power_down_n, i_clock_role_select;
  logic [7:0] i_wb_adr;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, rd;
  logic o_wb_ack, o_serial_bit_clock, o_serial_bit_clock_oe, o_frame_clock, o_frame_clock_oe;
  logic o_stream_bit_clock, i_serial_bit_clock, i_frame_clock, host_run, v0;
  logic [1:0] o_pcm_data_out, o_stream_left_out, o_stream_right_out;
  logic [9:0] frames; // frame count seen before a power-down pulse
  int num_errors, check_count, c;

  adc_audio_output_port u_adc_audio_output_port (.i_mclk, .i_sys_rst, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_power_down_n,
    .i_clock_role_select, .i_serial_bit_clock, .o_serial_bit_clock, .o_serial_bit_clock_oe,
    .i_frame_clock, .o_frame_clock, .o_frame_clock_oe, .o_pcm_data_out, .o_stream_bit_clock,
    .o_stream_left_out, .o_stream_right_out);
  audio_host_model u_audio_host_model (.i_run(host_run), .o_bit_clock(i_serial_bit_clock),
    .o_frame_clock(i_frame_clock));

  // ==========================================================
  // reference clock of 10 ns
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  // one classic cycle; waits for ack, takes read data at that edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    c = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= adr;
    i_wb_dat <= dat;
    do
    begin
      @(posedge i_mclk);
      c++;
    end
    while (o_wb_ack !== 1'b1 && c < 50);
    if (c >= 50)
      num_errors++;
    rd = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_mclk);
  endtask

  // read and compare the masked value
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    `CHECK(rd & mask, exp)
  endtask

  // channel reset around every mode change
  task automatic mode(input logic [31:0] v);
    wb(1'b1, REG_CTRL, v & 32'hffff_ffbf);
    wb(1'b1, REG_CTRL, v);
  endtask

  // sel 0 frame clock, 1 stream clock
  function automatic logic sig(input int sel);
    return sel ? o_stream_bit_clock : o_frame_clock;
  endfunction

  // count edges until the chosen clock reaches lvl
  task automatic edge_of(input int sel, input logic lvl, output int n);
    logic prev;
    n = 0;
    do
    begin
      prev = sig(sel);
      @(posedge i_mclk);
      n++;
    end
    while (!(sig(sel) === lvl && prev === !lvl) && n < 20000);
  endtask

  // rise to rise period in reference cycles
  task automatic period(input int sel, input int exp);
    int n;
    edge_of(sel, 1'b1, n);
    edge_of(sel, 1'b1, n);
    `CHECK(n, exp)
  endtask

  // verdict and end of run
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    #1_000_000;
    num_errors++;
    tally_and_finish;
  end

  // ==========================================================
  // main sequence
  initial
  begin
    {i_sys_rst, i_power_down_n, i_clock_role_select} = 3'h7;
    {i_wb_cyc, i_wb_stb, i_wb_we, host_run} = 4'h0;
    {i_wb_adr, i_wb_sel, i_wb_dat} = '0;
    num_errors = 0;
    check_count = 0;
    repeat (20) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    i_wb_sel <= 4'hf;
    repeat (10) @(posedge i_mclk);
    rd_chk(REG_CTRL, 32'hffff_ffff, CTRL_RESET);
    rd_chk(REG_STATUS, 32'h1f, 32'h04);
    wb(1'b1, 8'h20, 32'hffff_ffff);
    rd_chk(8'h20, 32'hffff_ffff, 32'h0);
    // master frame sizes 64, 128, 256, 512 bits of 16 cycles
    for (int k = 0; k < 4; k++)
    begin
      mode(32'h0f40 | (k << 4));
      period(0, 1024 << k);
      `CHECK(o_pcm_data_out, 2'h0)
    end
    // stream mode ignores the role pin and stays master
    i_clock_role_select <= 1'b0;
    wb(1'b1, REG_STREAM_DATA, 32'h55aa_55aa);
    for (int r = 0; r < 3; r++)
    begin
      mode(32'h0f41 | (r << 2));
      period(1, 16 >> r);
    end
    rd_chk(REG_STATUS, 32'h1f, 32'h08);
    // launch edge: only the chosen edge moves the alternating bits
    for (int e = 0; e < 2; e++)
    begin
      mode(32'h0f41 | (e << 1));
      for (int lvl = 0; lvl < 2; lvl++)
      begin
        edge_of(1, lvl[0], c);
        v0 = o_stream_left_out[0];
        repeat (3) @(posedge i_mclk);
        `CHECK(o_stream_left_out[0] !== v0, lvl == e)
        `CHECK(o_stream_right_out ^ o_stream_left_out, 2'h3)
        `CHECK(o_stream_left_out[1], o_stream_left_out[0])
      end
    end
    // slave mode with the host driving the clocks
    host_run <= 1'b1;
    mode(32'h0f40);
    repeat (3000) @(posedge i_mclk);
    rd_chk(REG_STATUS, 32'h1f, 32'h10);
    `CHECK(o_serial_bit_clock_oe, 1'b0)
    `CHECK(o_pcm_data_out, 2'h0)
    `CHECK(rd[25:16] >= 10'h002, 1'b1)
    frames = rd[25:16];
    // a 20 ns low is ignored
    i_power_down_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_power_down_n <= 1'b1;
    repeat (10) @(posedge i_mclk);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHECK(rd[25:16] >= frames && rd[1] === 1'b0, 1'b1)
    // a 160 ns low resets and clears the frame count
    i_power_down_n <= 1'b0;
    repeat (16) @(posedge i_mclk);
    rd_chk(REG_STATUS, 32'h03ff_0002, 32'h0000_0002);
    i_power_down_n <= 1'b1;
    repeat (2500) @(posedge i_mclk);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHECK(rd[25:16] >= 10'h001 && rd[0] === 1'b0, 1'b1)
    tally_and_finish;
  end
endmodule
